// [hbfc_top.sv]
// Full-bridge control, decode and fault supervision
`timescale 1ns/1ns
module hbfc_top
#(
  parameter int unsigned RETRY_CYCLES = hbfc_pkg::RETRY_CYC
)
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  // Controller commands
  input  hbfc_pkg::hbfc_cmd_t       cmd,
  // Analogue monitor events
  input  hbfc_pkg::hbfc_mon_t       mon,
  // Bridge gate drives
  output hbfc_pkg::hbfc_gate_t      bridge_leg_a,
  output hbfc_pkg::hbfc_gate_t      bridge_leg_b,
  // Regulator and charge pump enable
  output logic                      rail_enable,
  // Open-drain fault flag
  output logic                      fault_flag_n_o,
  output logic                      fault_flag_n_oe
);

  hbfc_pkg::hbfc_sc_t               sc_r;       // Short retry state
  hbfc_pkg::hbfc_sc_t               sc_nxt;
  logic [hbfc_pkg::RETRY_W-1:0]     tmr_r;      // Retry timer
  logic [hbfc_pkg::RETRY_W-1:0]     tmr_nxt;
  logic                             tsd_r;      // Thermal shutdown latched
  logic                             tsd_nxt;
  logic                             flag_r;     // Fault flag asserted
  logic                             flag_nxt;
  logic                             rail_r;
  logic                             rail_nxt;
  logic                             fz_r;       // Fast decay at zero current
  logic                             fz_nxt;
  logic                             disable_all;
  hbfc_pkg::hbfc_leg_t              req_a;
  hbfc_pkg::hbfc_leg_t              req_b;

  // Map a drive polarity to a leg pair value
  function automatic hbfc_pkg::hbfc_leg_t leg_of(input logic hi);
    leg_of = hi ? hbfc_pkg::HBFC_LEG_HIGH : hbfc_pkg::HBFC_LEG_LOW;
  endfunction

  // Short fault retry timing
  always_comb
  begin
    sc_nxt  = sc_r;
    tmr_nxt = tmr_r;
    case (sc_r)
      hbfc_pkg::HBFC_SC_RUN:
      begin
        if (mon.short_detect && cmd.sleep_n)
        begin
          // Bridge off and timer started
          sc_nxt  = hbfc_pkg::HBFC_SC_WAIT;
          tmr_nxt = hbfc_pkg::RETRY_W'(RETRY_CYCLES - 1);
        end
      end
      hbfc_pkg::HBFC_SC_WAIT:
      begin
        if (tmr_r != '0)
          tmr_nxt = tmr_r - 1'b1;
        else
          sc_nxt = hbfc_pkg::HBFC_SC_RETRY;  // Follow inputs again
      end
      hbfc_pkg::HBFC_SC_RETRY:
      begin
        if (mon.short_detect)
        begin
          // Short still there, repeat cycle
          sc_nxt  = hbfc_pkg::HBFC_SC_WAIT;
          tmr_nxt = hbfc_pkg::RETRY_W'(RETRY_CYCLES - 1);
        end
        else
          sc_nxt = hbfc_pkg::HBFC_SC_RUN;  // Clear, release flag
      end
      default:
        sc_nxt = hbfc_pkg::HBFC_SC_RUN;
    endcase
    if (!cmd.sleep_n)
      sc_nxt = hbfc_pkg::HBFC_SC_RUN;
  end

  // Fault flag, thermal latch and rail enable
  always_comb
  begin
    // Shutdown holds until monitor shows cooled past hysteresis
    tsd_nxt  = mon.thermal_shutdown;
    rail_nxt = cmd.sleep_n;  // Sleep stops regulator and pump
    // Flag sources, warning included
    flag_nxt = (sc_nxt == hbfc_pkg::HBFC_SC_WAIT) || (sc_nxt == hbfc_pkg::HBFC_SC_RETRY && mon.short_detect)
               || mon.sink_gate_supply_fault || mon.pump_reservoir_rail_fault
               || mon.supply_low_lockout || mon.thermal_warn || mon.thermal_shutdown;
    // Fast decay stops at zero current until next drive or slow decay
    fz_nxt = fz_r;
    if (cmd.enable || cmd.decay)
      fz_nxt = 1'b0;
    else if (mon.current_near_zero)
      fz_nxt = 1'b1;
  end

  // Register supervision state
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sc_r   <= hbfc_pkg::HBFC_SC_RUN;
      tmr_r  <= '0;
      tsd_r  <= 1'b0;
      flag_r <= hbfc_pkg::FLAG_RST;
      rail_r <= 1'b0;
      fz_r   <= 1'b0;
    end
    else
    begin
      sc_r   <= sc_nxt;
      tmr_r  <= tmr_nxt;
      tsd_r  <= tsd_nxt;
      flag_r <= flag_nxt;
      rail_r <= rail_nxt;
      fz_r   <= fz_nxt;
    end
  end

  // Disabling faults; warning is deliberately absent
  assign disable_all = mon.sink_gate_supply_fault
                     | mon.pump_reservoir_rail_fault
                     | mon.supply_low_lockout
                     | tsd_r | mon.thermal_shutdown
                     | (sc_r == hbfc_pkg::HBFC_SC_WAIT);

  // Leg decode, with priority sleep, then faults, then inputs
  always_comb
  begin
    req_a = hbfc_pkg::HBFC_LEG_OFF;
    req_b = hbfc_pkg::HBFC_LEG_OFF;
    if (!cmd.sleep_n)
    begin
      // Both legs high impedance
      req_a = hbfc_pkg::HBFC_LEG_OFF;
      req_b = hbfc_pkg::HBFC_LEG_OFF;
    end
    else if (disable_all)
    begin
      // Disabled while fault lasts or short timer runs, resumes after
      req_a = hbfc_pkg::HBFC_LEG_OFF;
      req_b = hbfc_pkg::HBFC_LEG_OFF;
    end
    else if (cmd.enable)
    begin
      // Forward or reverse drive
      req_a = leg_of(cmd.dir);
      req_b = leg_of(!cmd.dir);
    end
    else if (cmd.decay)
    begin
      // Slow decay: both sinks on, synchronous
      req_a = hbfc_pkg::HBFC_LEG_LOW;
      req_b = hbfc_pkg::HBFC_LEG_LOW;
    end
    else if (!fz_r)
    begin
      // Fast decay: opposite drivers, synchronous
      req_a = leg_of(!cmd.dir);
      req_b = leg_of(cmd.dir);
    end
  end

  // Leg A driver
  hbfc_leg u_leg_a
  (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .req     (req_a),
    .gate    (bridge_leg_a)
  );

  // Leg B driver
  hbfc_leg u_leg_b
  (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .req     (req_b),
    .gate    (bridge_leg_b)
  );

  // Open drain: pull low while flag set
  assign fault_flag_n_o  = 1'b0;
  assign fault_flag_n_oe = flag_r;
  assign rail_enable     = rail_r;

endmodule

// [hbfc_pkg.sv]
// Package with constants and types for the full-bridge fault control block
// Functional notes
// - Sink gate supply fault disables all outputs
// - Pump reservoir fault disables all outputs
// - Rail or thermal disable lasts while fault persists
// - Power-on lockout holds drivers disabled
// - Low sleep input shuts regulator and pump
// - Decay select high means slow decay
// - Synchronous rectification always on
// - Short: bridge off, flag low, start timer
// - Timer expiry retries; persistent short repeats cycle
// - Short gone after expiry releases flag
// - Flag low on short, undervoltage, warning
// - Thermal warning flags only, bridge keeps running
// - Shutdown at 175, re-enable after hysteresis
// - Dead time between leg driver switchovers
// - Fast decay drives opposite to drive state
// - Fast decay drivers off near zero current
// - Slow decay turns both sink drivers on
// - Decode enable, direction, decay into leg states
package hbfc_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ          = 50_000_000;
  // Crossover dead time, ns
  localparam int unsigned DEAD_TIME_NS    = 500;
  localparam int unsigned DEAD_CYC        = (DEAD_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Short retry period, us
  localparam int unsigned RETRY_US        = 1200;
  localparam int unsigned RETRY_CYC       = RETRY_US * (CLK_HZ / 1_000_000);
  // Wake settle time the controller must allow, us
  localparam int unsigned WAKE_SETTLE_US  = 1000;
  // Counter widths
  localparam int unsigned DEAD_W          = 5;
  localparam int unsigned RETRY_W         = 17;
  // Reset values
  localparam logic        FLAG_RST        = 1'b0;

  // Requested state of one leg
  typedef enum logic [1:0]
  {
    HBFC_LEG_OFF  = 2'b00,
    HBFC_LEG_LOW  = 2'b01,
    HBFC_LEG_HIGH = 2'b10
  } hbfc_leg_t;

  // Short-retry state machine
  typedef enum logic [1:0]
  {
    HBFC_SC_RUN   = 2'b00,
    HBFC_SC_WAIT  = 2'b01,
    HBFC_SC_RETRY = 2'b10
  } hbfc_sc_t;

  // Controller command inputs
  typedef struct packed
  {
    logic dir;      // Direction select
    logic enable;   // Enable chop, high drives
    logic decay;    // High slow, low fast
    logic sleep_n;  // Low puts device to sleep
  } hbfc_cmd_t;

  // Analogue monitor events
  typedef struct packed
  {
    logic sink_gate_supply_fault;
    logic pump_reservoir_rail_fault;
    logic supply_low_lockout;
    logic thermal_warn;
    logic thermal_shutdown;
    logic short_detect;
    logic current_near_zero;
  } hbfc_mon_t;

  // Gate drive of one leg
  typedef struct packed
  {
    logic src_on;
    logic snk_on;
  } hbfc_gate_t;

endpackage

// [hbfc_leg.sv]
// One bridge leg driver with crossover dead time
`timescale 1ns/1ns
module hbfc_leg
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  // Requested leg state
  input  hbfc_pkg::hbfc_leg_t       req,
  // Gate drives
  output hbfc_pkg::hbfc_gate_t      gate
);

  hbfc_pkg::hbfc_leg_t              cur_r;   // Leg state being driven
  hbfc_pkg::hbfc_leg_t              cur_nxt;
  logic [hbfc_pkg::DEAD_W-1:0]      dead_r;  // Dead-time countdown
  logic [hbfc_pkg::DEAD_W-1:0]      dead_nxt;
  hbfc_pkg::hbfc_gate_t             gate_r;
  hbfc_pkg::hbfc_gate_t             gate_nxt;

  // Next leg state: go off at once, wait dead time before turning on
  always_comb
  begin
    cur_nxt  = cur_r;
    dead_nxt = dead_r;
    if (req != cur_r)
    begin
      if (cur_r != hbfc_pkg::HBFC_LEG_OFF)
      begin
        // Any change first drops both switches
        cur_nxt  = hbfc_pkg::HBFC_LEG_OFF;
        dead_nxt = hbfc_pkg::DEAD_W'(hbfc_pkg::DEAD_CYC);
      end
      else if (req == hbfc_pkg::HBFC_LEG_OFF)
        dead_nxt = dead_r;
      else if (dead_r != '0)
        dead_nxt = dead_r - 1'b1;  // Still inside crossover gap
      else
        cur_nxt = req;
    end
    else if (cur_r == hbfc_pkg::HBFC_LEG_OFF && dead_r != '0)
      dead_nxt = dead_r - 1'b1;
    gate_nxt.src_on = (cur_nxt == hbfc_pkg::HBFC_LEG_HIGH);
    gate_nxt.snk_on = (cur_nxt == hbfc_pkg::HBFC_LEG_LOW);
  end

  // Register leg state
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cur_r  <= hbfc_pkg::HBFC_LEG_OFF;
      dead_r <= hbfc_pkg::DEAD_W'(hbfc_pkg::DEAD_CYC);
      gate_r <= '0;
    end
    else
    begin
      cur_r  <= cur_nxt;
      dead_r <= dead_nxt;
      gate_r <= gate_nxt;
    end
  end

  assign gate = gate_r;

endmodule

// [hbfc_top_monitor.sv]
// Port-level checks on the full-bridge control block
`timescale 1ns/1ns
module hbfc_top_monitor
#(
  parameter int unsigned RETRY_CYCLES = 50
)
(
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rstn,
  // Inputs watched
  input  hbfc_pkg::hbfc_cmd_t cmd,
  input  hbfc_pkg::hbfc_mon_t mon,
  // Outputs watched
  input  hbfc_pkg::hbfc_gate_t bridge_leg_a,
  input  hbfc_pkg::hbfc_gate_t bridge_leg_b,
  input  wire logic           rail_enable,
  input  wire logic           fault_flag_n_o,
  input  wire logic           fault_flag_n_oe
);
  // Both legs fully off
  wire off = (bridge_leg_a == 2'h0) && (bridge_leg_b == 2'h0);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  flag_pin_a: assert property (fault_flag_n_o == 1'h0)
    else $error("flag pin drives high");
  dead_time_a: assert property ($rose(bridge_leg_a.src_on) |-> !$past(bridge_leg_a.snk_on, 20))
    else $error("leg a source on without gap");
  sleep_off_a: assert property (!cmd.sleep_n |=> off)
    else $error("legs driven in sleep");
  rail_on_a: assert property (1'h1 |=> rail_enable == $past(cmd.sleep_n))
    else $error("rail enable wrong");
  sink_off_a: assert property (mon.sink_gate_supply_fault |=> off)
    else $error("legs on with sink supply fault");
  pump_off_a: assert property (mon.pump_reservoir_rail_fault |=> off)
    else $error("legs on with pump fault");
  lock_off_a: assert property (mon.supply_low_lockout |=> off)
    else $error("legs on in lockout");
  hot_off_a: assert property (mon.thermal_shutdown |=> off)
    else $error("legs on when overheated");
  short_flag_a: assert property (cmd.sleep_n && mon.short_detect |=> fault_flag_n_oe)
    else $error("short not flagged");
  // A retry may turn the legs on for a moment, so only a fresh short in normal running is held
  short_off_a: assert property (cmd.sleep_n && mon.short_detect && !fault_flag_n_oe |-> ##2 off)
    else $error("legs on after short");
  warn_flag_a: assert property (mon.thermal_warn |=> fault_flag_n_oe)
    else $error("warning not flagged");
  flag_cause_a: assert property ($rose(fault_flag_n_oe) |-> ($past(mon) & 7'h7e) != 7'h0)
    else $error("flag without a cause");
  // Zero current latches one cycle late, so the fast-decay condition must stand for two cycles
  zero_off_a: assert property ((cmd.sleep_n && !cmd.enable && !cmd.decay && mon == 7'h01) [*2]
    |=> off)
    else $error("fast decay past zero current");
endmodule
bind hbfc_top hbfc_top_monitor #(.RETRY_CYCLES(RETRY_CYCLES)) chk_i (.ref_clk(ref_clk),
  .rstn(rstn), .cmd(cmd), .mon(mon), .bridge_leg_a(bridge_leg_a),
  .bridge_leg_b(bridge_leg_b), .rail_enable(rail_enable),
  .fault_flag_n_o(fault_flag_n_o), .fault_flag_n_oe(fault_flag_n_oe));

// [hbfc_ctrl_model.sv]
// Motor controller model driving the command pins
`timescale 1ns/1ns
module hbfc_ctrl_model
#(
  parameter int unsigned WAKE_CYC = 10
)
(
  // Clock
  input  wire logic            ref_clk,
  // Requested commands and flag pin level
  input  hbfc_pkg::hbfc_cmd_t  want,
  input  wire logic            flag_pin,
  // Command pins and flag as read
  output hbfc_pkg::hbfc_cmd_t  cmd,
  output logic                 fault_seen
);
  int wake;  // Cycles awake
  hbfc_pkg::hbfc_cmd_t next_cmd;  // Pin values for the coming cycle
  initial cmd = 4'h0;
  // Update pins at the falling edge; no chop until the pump settles
  always @(negedge ref_clk)
  begin
    wake = want.sleep_n ? wake + 1 : 0;
    next_cmd = want;
    if (wake < WAKE_CYC)
      next_cmd.enable = 1'h0;
    cmd <= next_cmd;
  end
  // Flag read as meaningless while asleep
  assign fault_seen = cmd.sleep_n & ~flag_pin;
endmodule

// [tb_top.sv]
// Bench for the full-bridge control block
`timescale 1ns/1ns
module tb_top;
  logic                 ref_clk = 1'h0;
  logic                 rstn = 1'h0;
  hbfc_pkg::hbfc_cmd_t  want = 4'h1;   // Awake
  hbfc_pkg::hbfc_mon_t  mon = 7'h10;   // Lockout at power-on
  hbfc_pkg::hbfc_cmd_t  cmd;
  hbfc_pkg::hbfc_gate_t leg_a;
  hbfc_pkg::hbfc_gate_t leg_b;
  logic                 rail_en;
  logic                 flag_o;
  logic                 flag_oe;
  logic                 seen;
  wire                  flag_pin = flag_oe ? flag_o : 1'h1; // Pull-up
  int                   n_fail = 0;
  int                   n_tests = 0;
  // Expected {leg a, leg b, rail, flag} per {dir, enable, decay}
  logic [5:0] tab [8] = '{6'h26, 6'h16, 6'h1a, 6'h1a, 6'h1a, 6'h16, 6'h26, 6'h26};
  logic [6:0] flt [3] = '{7'h40, 7'h20, 7'h04};
  always #10 ref_clk = ~ref_clk;
  hbfc_top #(.RETRY_CYCLES(50)) dut (.ref_clk(ref_clk), .rstn(rstn), .cmd(cmd), .mon(mon),
    .bridge_leg_a(leg_a), .bridge_leg_b(leg_b), .rail_enable(rail_en),
    .fault_flag_n_o(flag_o), .fault_flag_n_oe(flag_oe));
  hbfc_ctrl_model ctrl (.ref_clk(ref_clk), .want(want), .flag_pin(flag_pin), .cmd(cmd),
    .fault_seen(seen));
  // Closing report
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Compare and count
  task automatic chk(string what, logic [5:0] got, logic [5:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Apply inputs, let the legs settle past the dead time, compare
  task automatic step(string what, logic [3:0] c, logic [6:0] m, logic [5:0] exp);
    @(negedge ref_clk);
    want = c;
    mon = m;
    repeat (40) @(negedge ref_clk);
    chk(what, {leg_a, leg_b, rail_en, seen}, exp);
    $display("done %s", what);
  endtask
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    give_verdict();
  end
  initial
  begin
    repeat (6) @(negedge ref_clk);
    chk("reset", {leg_a, leg_b, rail_en, seen}, 6'h00);
    rstn = 1'h1;
    step("lockout", 4'hd, 7'h10, 6'h03);
    for (int i = 0; i < 8; i++)
      step("decode", {3'(i), 1'h1}, 7'h00, tab[i]);
    step("brake", 4'h3, 7'h00, 6'h16);
    step("zero", 4'h9, 7'h01, 6'h02);
    step("zero_clr", 4'hd, 7'h00, 6'h26);
    for (int i = 0; i < 3; i++)
    begin
      step("fault", 4'hd, flt[i], 6'h03);
      step("resume", 4'hd, 7'h00, 6'h26);
    end
    step("warn", 4'hd, 7'h08, 6'h27);
    step("short", 4'hd, 7'h02, 6'h03);
    step("short_hold", 4'hd, 7'h02, 6'h03);
    repeat (60) @(negedge ref_clk);
    step("short_gone", 4'hd, 7'h00, 6'h26);
    step("sleep", 4'hc, 7'h00, 6'h00);
    step("sleep_flt", 4'hc, 7'h42, 6'h00);
    want = 4'hd;
    mon = 7'h00;
    repeat (30) @(negedge ref_clk);
    step("wake", 4'hd, 7'h00, 6'h26);
    give_verdict();
  end
endmodule
